// [inc/pwmc_map.svh]
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH
// Functional notes
// RQ1: one shared clock generator feeds four independent waveform channels.
// RQ2: every channel owns a 16-bit counter advanced by its selected clock.
// RQ3: prescaler gives eleven taps: undivided, then divided by 2 up to 1024.
// RQ4: two linear dividers give divided clocks A and B, ratio 1 to 255.
// RQ5: each divider picks its own prescaler tap by its source-select field.
// RQ6: divided clock equals the selected tap divided by the factor field.
// RQ7: factor and source fields reset to zero; zero factor turns the clock off.
// RQ8: taps other than undivided are idle at reset and while clock is gated.
// RQ9: thirteen clocks offered; each channel picks any one independently.
// RQ10: after a clock stop and restart, operation resumes from preserved state.
// RQ11: all registers writable ungated; all but duty and period readable ungated.
// RQ12: period or duty changes while running are double buffered.
// RQ13: each channel has its own enable and disable command.
// RQ14: software picks each channel's start level (polarity).
// RQ15: left or center alignment is selected per channel.
// RQ16: each channel drives exactly one waveform output line.
// RQ17: the interrupt line should be handled as level sensitive outside.
// RQ18: channels can be started together to give non-overlapping waveforms.
// RQ19: center counts up to period then down to zero; left wraps at period.
// RQ20: pending update waits to period end, then loads period or duty.
// RQ21: period end sets the event flag; unmasked flags hold interrupt until read.
// RQ22: polarity and alignment writes are ignored while the channel runs.
// RQ23: derived clocks are one-cycle enables on the main clock.
// RQ24: factor N emits one enable for every N pulses of the selected tap.

// sizes
`define PWMC_NCH      4
`define PWMC_NTAP     4'hB
`define PWMC_NCLK     4'hD

// global register offsets
`define PWMC_OFF_MODE 8'h00
`define PWMC_OFF_ENA  8'h04
`define PWMC_OFF_DIS  8'h08
`define PWMC_OFF_SR   8'h0C
`define PWMC_OFF_IER  8'h10
`define PWMC_OFF_IDR  8'h14
`define PWMC_OFF_IMR  8'h18
`define PWMC_OFF_ISR  8'h1C

// per-channel block: base 0x20, stride 0x20, word index in addr[4:2]
`define PWMC_CH_CMR   3'h0
`define PWMC_CH_DTY   3'h1
`define PWMC_CH_PRD   3'h2
`define PWMC_CH_CNT   3'h3
`define PWMC_CH_UPD   3'h4

// field positions
`define PWMC_DIVIDER_A_FACTOR_LSB 0
`define PWMC_DIVIDER_A_SOURCE_SELECT_LSB 8
`define PWMC_DIVIDER_B_FACTOR_LSB 16
`define PWMC_DIVIDER_B_SOURCE_SELECT_LSB 24
`define PWMC_SEL_LSB  0
`define PWMC_ALG_BIT  8
`define PWMC_POL_BIT  9
`define PWMC_UPD_BIT  10

// reset values
`define PWMC_MODE_RST 24'h000000
`define PWMC_CMR_RST  7'h00
`define PWMC_VAL_RST  16'h0000
`endif

// [inc/pwmc_pkg.sv]
package pwmc_pkg;
`include "pwmc_map.svh"

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pwmc_bus_s;

   typedef struct packed {
      logic [3:0] dividerBSourceSelect;
      logic [7:0] dividerBFactor;
      logic [3:0] dividerASourceSelect;
      logic [7:0] dividerAFactor;
   } pwmc_mode_s;

   typedef struct packed {
      logic       updateTargetSelect;
      logic       startLevelSelect;
      logic       alignmentSelect;
      logic [3:0] clkSel;
   } pwmc_chcfg_s;

   typedef logic [12:0] pwmc_tick_t;

   typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} pwmc_dir_e;

   // pick one enable out of the clock vector, none for codes past the end
   function automatic logic pwmc_pick(input pwmc_tick_t t, input logic [3:0] s);
      return (s < `PWMC_NCLK) ? t[s] : 1'b0;
   endfunction
endpackage

// [verilog/pwmc_clkgen.sv]
`timescale 1ns/1ns
module pwmc_clkgen (
   // clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // power manager gate and divider settings
   input  wire logic           pclkEn,
   input  pwmc_pkg::pwmc_mode_s mode,
   // one-cycle enables: taps 0..10, then divided clocks a and b
   output pwmc_pkg::pwmc_tick_t ticks
);
   import pwmc_pkg::*;

   logic [9:0]      pre_r;
   logic [7:0]      divCnt_r [2];
   logic [1:0][7:0] fac;
   logic [1:0][3:0] sel;
   logic [1:0]      srcTick;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   assign fac[0] = mode.dividerAFactor;
   assign fac[1] = mode.dividerBFactor;
   assign sel[0] = mode.dividerASourceSelect;
   assign sel[1] = mode.dividerBSourceSelect;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler, frozen while gated so it resumes where it stopped
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pre_r <= 10'h000;
      else if (pclkEn)
         pre_r <= pre_r + 10'h001; // RQ10
   end

   // enables instead of clock nets keep everything on one clock
   assign ticks[0] = pclkEn; // RQ23
   genvar k;
   for (k = 1; k < 11; k++) begin : gTap
      assign ticks[k] = pclkEn && (&pre_r[k-1:0]); // RQ3 RQ8
   end

   ////////////////////////////////////////////////////////////////////////////
   // linear dividers a and b
   genvar d;
   for (d = 0; d < 2; d++) begin : gDiv
      assign srcTick[d] = (sel[d] < `PWMC_NTAP) && pwmc_pick(ticks, sel[d]); // RQ5
      // count source pulses, one output per factor pulses
      always_ff @(posedge clk or posedge rst) begin
         if (rst)
            divCnt_r[d] <= 8'h00;
         else if (fac[d] == 8'h00)
            divCnt_r[d] <= 8'h00; // RQ7
         else if (srcTick[d])
            divCnt_r[d] <= (divCnt_r[d] >= fac[d] - 8'h01) ? 8'h00 : divCnt_r[d] + 8'h01; // RQ24
      end
      assign ticks[11+d] = srcTick[d] && (fac[d] != 8'h00)
                           && (divCnt_r[d] == fac[d] - 8'h01); // RQ4 RQ6

      AST_DIV_SOURCE: assert property ( // RQ24
         ticks[11+d] |-> srcTick[d] && fac[d] != 8'h00)
         else $error("divided clock pulsed without a source pulse");
   end

   AST_GATED_QUIET: assert property ( // RQ8
      !pclkEn |-> ticks == 13'h0000)
      else $error("clock enable seen while gated");
   AST_DIV_OFF: assert property ( // RQ7
      fac[0] == 8'h00 |-> !ticks[11])
      else $error("divided clock a running with zero factor");
   AST_TAP4_SPACING: assert property ( // RQ3
      ticks[2] |=> !ticks[2] [*3])
      else $error("divide-by-4 tap pulsed too soon");
endmodule

// [verilog/pwmc_top.sv]
`timescale 1ns/1ns
module pwmc_top (
   // clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // power manager clock gate
   input  wire logic           pclkEn,
   // register port
   input  pwmc_pkg::pwmc_bus_s bus,
   output logic [31:0]         rdData,
   // waveforms and interrupt
   output logic [3:0]          waveOut,
   output logic                irq
);
   import pwmc_pkg::*;

   pwmc_mode_s  clockgenMode_r;
   pwmc_tick_t  ticks;
   pwmc_chcfg_s chCfg_r [4];
   pwmc_dir_e   dir_r [4];
   logic [15:0] dutyValue_r [4];
   logic [15:0] periodValue_r [4];
   logic [15:0] pendingUpdate_r [4];
   logic [15:0] cnt_r [4];
   logic        wave_r [4];
   logic [3:0]  updPend_r;
   logic [3:0]  chEn_r;
   logic [3:0]  intMask_r;
   logic [3:0]  chanEventStatus_r;
   logic [3:0]  chEnd;
   logic [31:0] rdData_r;
   logic [31:0] rdVal;
   logic        wrMode;
   logic        wrEna;
   logic        wrDis;
   logic        wrIer;
   logic        wrIdr;
   logic        rdIsr;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // channel window decode, shared by writes and reads
   function automatic logic chHit(input logic [7:0] a, input logic [1:0] ch,
                                  input logic [2:0] idx);
      return (a[7:5] == {1'b0, ch} + 3'h1) && (a[4:2] == idx) && (a[1:0] == 2'h0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // global decode; writes need no gate clock
   assign wrMode = bus.wr && bus.addr == `PWMC_OFF_MODE; // RQ11
   assign wrEna  = bus.wr && bus.addr == `PWMC_OFF_ENA;
   assign wrDis  = bus.wr && bus.addr == `PWMC_OFF_DIS;
   assign wrIer  = bus.wr && bus.addr == `PWMC_OFF_IER;
   assign wrIdr  = bus.wr && bus.addr == `PWMC_OFF_IDR;
   assign rdIsr  = bus.rd && bus.addr == `PWMC_OFF_ISR;

   // clock generator mode register
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         clockgenMode_r <= `PWMC_MODE_RST; // RQ7
      else if (wrMode)
         clockgenMode_r <= '{dividerBSourceSelect: bus.wdata[`PWMC_DIVIDER_B_SOURCE_SELECT_LSB +: 4],
                             dividerBFactor:       bus.wdata[`PWMC_DIVIDER_B_FACTOR_LSB +: 8],
                             dividerASourceSelect: bus.wdata[`PWMC_DIVIDER_A_SOURCE_SELECT_LSB +: 4],
                             dividerAFactor:       bus.wdata[`PWMC_DIVIDER_A_FACTOR_LSB +: 8]};
   end

   // one shared generator for all channels
   pwmc_clkgen uClkgen ( // RQ1
      .clk    (clk),
      .rst    (rst),
      .pclkEn (pclkEn),
      .mode   (clockgenMode_r),
      .ticks  (ticks)
   );

   ////////////////////////////////////////////////////////////////////////////
   // per-channel enable; several bits in one write start channels together
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         chEn_r <= 4'h0;
      else if (wrEna)
         chEn_r <= chEn_r | bus.wdata[3:0]; // RQ13 RQ18
      else if (wrDis)
         chEn_r <= chEn_r & ~bus.wdata[3:0]; // RQ13
   end

   // interrupt mask, set and cleared through separate addresses
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         intMask_r <= 4'h0;
      else if (wrIer)
         intMask_r <= intMask_r | bus.wdata[3:0];
      else if (wrIdr)
         intMask_r <= intMask_r & ~bus.wdata[3:0];
   end

   // event flags clear on status read; a same-cycle event still lands
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         chanEventStatus_r <= 4'h0;
      else
         chanEventStatus_r <= (rdIsr ? 4'h0 : chanEventStatus_r) | chEnd; // RQ21
   end

   // level output; an edge-triggered sink could miss a second event
   assign irq = |(chanEventStatus_r & intMask_r); // RQ21 RQ17

   ////////////////////////////////////////////////////////////////////////////
   // channels
   genvar i;
   for (i = 0; i < 4; i++) begin : gCh
      logic        tick;
      logic        lastLeft;
      logic [16:0] cntInc;
      logic        wrCmr;
      logic        wrDty;
      logic        wrPrd;
      logic        wrUpd;

      assign wrCmr  = bus.wr && chHit(bus.addr, 2'(i), `PWMC_CH_CMR);
      assign wrDty  = bus.wr && chHit(bus.addr, 2'(i), `PWMC_CH_DTY);
      assign wrPrd  = bus.wr && chHit(bus.addr, 2'(i), `PWMC_CH_PRD);
      assign wrUpd  = bus.wr && chHit(bus.addr, 2'(i), `PWMC_CH_UPD);
      assign tick   = chEn_r[i] && pwmc_pick(ticks, chCfg_r[i].clkSel); // RQ9 RQ2
      assign cntInc = {1'b0, cnt_r[i]} + 17'h00001;
      assign lastLeft = cntInc >= {1'b0, periodValue_r[i]};
      // period ends on the left wrap or on the return to zero
      assign chEnd[i] = tick && (chCfg_r[i].alignmentSelect
                                 ? (dir_r[i] == DIR_DOWN && cnt_r[i] <= 16'h0001)
                                 : lastLeft); // RQ19

      // mode: polarity and alignment locked while running
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            chCfg_r[i] <= `PWMC_CMR_RST;
         end else if (wrCmr) begin
            chCfg_r[i].clkSel             <= bus.wdata[`PWMC_SEL_LSB +: 4];
            chCfg_r[i].updateTargetSelect <= bus.wdata[`PWMC_UPD_BIT];
            if (!chEn_r[i]) begin
               chCfg_r[i].startLevelSelect <= bus.wdata[`PWMC_POL_BIT]; // RQ14 RQ22
               chCfg_r[i].alignmentSelect  <= bus.wdata[`PWMC_ALG_BIT]; // RQ15 RQ22
            end
         end
      end

      // pending update; a fresh write beats the end-of-period clear
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            pendingUpdate_r[i] <= `PWMC_VAL_RST;
            updPend_r[i]       <= 1'b0;
         end else if (wrUpd) begin
            pendingUpdate_r[i] <= bus.wdata[15:0]; // RQ20
            updPend_r[i]       <= 1'b1;
         end else if (chEnd[i]) begin
            updPend_r[i]       <= 1'b0;
         end
      end

      // working values: direct only when idle, else at period end
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            dutyValue_r[i]   <= `PWMC_VAL_RST;
            periodValue_r[i] <= `PWMC_VAL_RST;
         end else if (!chEn_r[i]) begin
            if (wrDty)
               dutyValue_r[i] <= bus.wdata[15:0];
            if (wrPrd)
               periodValue_r[i] <= bus.wdata[15:0];
         end else if (chEnd[i] && updPend_r[i]) begin
            if (chCfg_r[i].updateTargetSelect)
               periodValue_r[i] <= pendingUpdate_r[i]; // RQ12 RQ20
            else
               dutyValue_r[i] <= pendingUpdate_r[i]; // RQ12 RQ20
         end
      end

      // counter; held at zero while idle so a joint enable starts aligned
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            cnt_r[i] <= 16'h0000;
            dir_r[i] <= DIR_UP;
         end else if (!chEn_r[i]) begin
            cnt_r[i] <= 16'h0000; // RQ18
            dir_r[i] <= DIR_UP;
         end else if (tick) begin
            case (dir_r[i])
               DIR_UP: begin
                  if (!chCfg_r[i].alignmentSelect) begin
                     cnt_r[i] <= lastLeft ? 16'h0000 : cntInc[15:0]; // RQ19
                  end else begin
                     cnt_r[i] <= cntInc[15:0];
                     if (lastLeft)
                        dir_r[i] <= DIR_DOWN; // RQ19
                  end
               end
               DIR_DOWN: begin
                  if (cnt_r[i] <= 16'h0001) begin
                     cnt_r[i] <= 16'h0000;
                     dir_r[i] <= DIR_UP;
                  end else begin
                     cnt_r[i] <= cnt_r[i] - 16'h0001;
                  end
               end
               default: begin
                  cnt_r[i] <= 16'h0000;
                  dir_r[i] <= DIR_UP;
               end
            endcase
         end
      end

      // output: start level below duty, idle level is the start level
      always_ff @(posedge clk or posedge rst) begin
         if (rst)
            wave_r[i] <= 1'b0;
         else if (!chEn_r[i])
            wave_r[i] <= chCfg_r[i].startLevelSelect; // RQ14
         else if (cnt_r[i] < dutyValue_r[i] || dutyValue_r[i] == periodValue_r[i])
            wave_r[i] <= chCfg_r[i].startLevelSelect;
         else
            wave_r[i] <= ~chCfg_r[i].startLevelSelect;
      end
      assign waveOut[i] = wave_r[i]; // RQ16

      sequence seqStart;
         !chEn_r[i] ##1 chEn_r[i];
      endsequence

      AST_EVT_FLAG: assert property ( // RQ21
         chEnd[i] |=> chanEventStatus_r[i])
         else $error("period end did not set event flag");
      AST_IDLE_LEVEL: assert property ( // RQ14
         !chEn_r[i] |=> waveOut[i] == $past(chCfg_r[i].startLevelSelect))
         else $error("idle output differs from start level");
      AST_POL_LOCK: assert property ( // RQ22
         chEn_r[i] |=> $stable(chCfg_r[i].startLevelSelect)
                      && $stable(chCfg_r[i].alignmentSelect))
         else $error("polarity or alignment changed while running");
      AST_LEFT_RANGE: assert property ( // RQ19
         chEn_r[i] && !chCfg_r[i].alignmentSelect && periodValue_r[i] != 16'h0000
         |-> cnt_r[i] < periodValue_r[i])
         else $error("left aligned counter passed period");
      AST_DBL_BUF: assert property ( // RQ12
         chEn_r[i] && !chEnd[i] |=> $stable(dutyValue_r[i]) && $stable(periodValue_r[i]))
         else $error("working value changed mid period");
      AST_SYNC_START: assert property ( // RQ18
         seqStart |-> cnt_r[i] == 16'h0000 && dir_r[i] == DIR_UP)
         else $error("channel did not start from zero");
      AST_CENTER_DOWN: assert property ( // RQ19
         chEn_r[i] && dir_r[i] == DIR_DOWN |-> cnt_r[i] != 16'h0000)
         else $error("center counter down at zero");
   end

   AST_IRQ_HOLD: assert property ( // RQ21
      irq && !rdIsr && !wrIdr |=> irq)
      else $error("interrupt dropped before status read");

   ////////////////////////////////////////////////////////////////////////////
   // read mux; duty and period read zero while the clock is gated
   always_comb begin
      rdVal = 32'h00000000;
      case (bus.addr)
         `PWMC_OFF_MODE: rdVal = {4'h0, clockgenMode_r[23:20], clockgenMode_r[19:12],
                                  4'h0, clockgenMode_r[11:8], clockgenMode_r[7:0]};
         `PWMC_OFF_SR:   rdVal = {28'h0000000, chEn_r};
         `PWMC_OFF_IMR:  rdVal = {28'h0000000, intMask_r};
         `PWMC_OFF_ISR:  rdVal = {28'h0000000, chanEventStatus_r};
         default: begin
            for (int j = 0; j < 4; j++) begin
               if (chHit(bus.addr, 2'(j), `PWMC_CH_CMR))
                  rdVal = {21'h000000, chCfg_r[j].updateTargetSelect,
                           chCfg_r[j].startLevelSelect, chCfg_r[j].alignmentSelect,
                           4'h0, chCfg_r[j].clkSel};
               if (chHit(bus.addr, 2'(j), `PWMC_CH_DTY) && pclkEn)
                  rdVal = {16'h0000, dutyValue_r[j]}; // RQ11
               if (chHit(bus.addr, 2'(j), `PWMC_CH_PRD) && pclkEn)
                  rdVal = {16'h0000, periodValue_r[j]}; // RQ11
               if (chHit(bus.addr, 2'(j), `PWMC_CH_CNT))
                  rdVal = {16'h0000, cnt_r[j]};
               if (chHit(bus.addr, 2'(j), `PWMC_CH_UPD))
                  rdVal = {16'h0000, pendingUpdate_r[j]};
            end
         end
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdData_r <= 32'h00000000;
      else
         rdData_r <= bus.rd ? rdVal : 32'h00000000;
   end
   assign rdData = rdData_r;
endmodule

// [sim/pwmc_load_model.sv]
`timescale 1ns/1ns
module pwmc_load_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // waveform lines and measurement gate
   input  wire logic [3:0]  waveOut,
   input  wire logic        measure,
   // cycles seen high on each line
   output logic [15:0]      hiCnt [4]
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // each load is its own line; an unknown level never counts as high
   always_ff @(posedge clk or posedge rst) begin
      for (int i = 0; i < 4; i++) begin
         if (rst) begin
            hiCnt[i] <= 16'h0000;
         end else if (measure && waveOut[i] === 1'b1) begin
            hiCnt[i] <= hiCnt[i] + 16'h0001;
         end
      end
   end
endmodule

// [sim/four_channel_pwm_clockgen_bench.sv]
`timescale 1ns/1ns
module four_channel_pwm_clockgen_bench;
   import pwmc_pkg::*;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            pclkEn = 1'b1;
   pwmc_bus_s       bus = '0;
   logic [31:0]     rdData;
   logic [3:0]      waveOut;
   logic            irq;
   logic            measure = 1'b0;
   logic [15:0]     hiCnt [4];
   int              fails = 0;
   int              tests_run = 0;
   int              seed;
   int              prd [4];
   int              dty [4];
   int              tpc [4];
   logic [31:0]     cmr [4];
   logic [31:0]     v;
   int              n;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   always #25 clk = ~clk;

   pwmc_top u_pwmc_top (.clk(clk), .rst(rst), .pclkEn(pclkEn), .bus(bus), .rdData(rdData),
                        .waveOut(waveOut), .irq(irq));
   pwmc_load_model u_pwmc_load_model (.clk(clk), .rst(rst), .waveOut(waveOut),
                                      .measure(measure), .hiCnt(hiCnt));
   ////////////////////////////////////////////////////////////////////////////////////////////
   // comparison, bus cycles, verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdData;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      rd(a, d);
      check(what, d, exp);
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // high cycles in a window that holds whole periods; duty equal to period holds the level
   function automatic int expHigh(int p, int d, bit ctr, bit pl, int win, int tp);
      int per;
      int on;
      per = tp * p * (ctr ? 2 : 1);
      on = ctr ? ((d == 0) ? 0 : ((d == p) ? 2 * p : 2 * d - 1)) : d;
      on = on * tp;
      return (pl ? on : per - on) * (win / per);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the roughly 600 cycles the tests take
   initial begin
      #(60000 * 50);
      fails++;
      stop_test();
   end

   initial begin
      seed = $urandom(74460);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check("waveOut reset", {28'h0, waveOut}, 32'h0000_0000);
      rdChk(8'h00, 32'h0000_0000, "mode reset");
      rdChk(8'h0C, 32'h0000_0000, "enabled reset");
      rdChk(8'h18, 32'h0000_0000, "mask reset");
      rdChk(8'h20, 32'h0000_0000, "cmr reset");
      rdChk(8'hF0, 32'h0000_0000, "unmapped");
      v = $urandom;
      wr(8'h00, v);
      rdChk(8'h00, v & 32'h0FFF_0FFF, "mode fields");
      // divider a: half-rate tap over 1 or 2; divider b: quarter-rate tap over 2
      n = 1 + $urandom_range(1);
      wr(8'h00, {4'h0, 4'h2, 8'h02, 4'h0, 4'h1, 8'(n)});
      prd = '{($urandom_range(1) ? 4 : 8), ($urandom_range(1) ? 2 : 4), 4, 4};
      tpc = '{1, 1, 2 * n, 8};
      for (int i = 0; i < 4; i++) begin
         dty[i] = $urandom_range(prd[i]);
         cmr[i] = {22'h0, 1'($urandom_range(1)), 1'(i == 1), 4'h0,
                   4'((i == 2) ? 11 : (i == 3) ? 12 : 0)};
         wr(8'(32 + 32 * i), cmr[i]);
         wr(8'(36 + 32 * i), 32'(dty[i]));
         wr(8'(40 + 32 * i), 32'(prd[i]));
      end
      wr(8'h04, 32'h0000_000F);
      rdChk(8'h0C, 32'h0000_000F, "enabled");
      repeat (64) @(posedge clk);
      measure <= 1'b1;
      repeat (320) @(posedge clk);
      measure <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         check("high cycles", 32'(hiCnt[i]),
               32'(expHigh(prd[i], dty[i], i == 1, cmr[i][9], 320, tpc[i])));
      end
      // running channel: settings locked, update waits for period end
      wr(8'h20, cmr[0] ^ 32'h0000_0200);
      rdChk(8'h20, cmr[0], "cmr locked");
      wr(8'h24, 32'(prd[0] - dty[0]));
      rdChk(8'h24, 32'(dty[0]), "duty locked");
      dty[0] = $urandom_range(prd[0]);
      wr(8'h30, 32'(dty[0]));
      repeat (28) @(posedge clk);
      rdChk(8'h24, 32'(dty[0]), "duty updated");
      // retarget the pending value at the period while still running
      wr(8'h20, cmr[0] | 32'h0000_0400);
      rdChk(8'h20, cmr[0] | 32'h0000_0400, "update target");
      wr(8'h30, 32'(prd[0] + 4));
      repeat (28) @(posedge clk);
      rdChk(8'h28, 32'(prd[0] + 4), "period updated");
      // event flag and interrupt line
      rd(8'h1C, v);
      wr(8'h10, 32'h0000_0001);
      rdChk(8'h18, 32'h0000_0001, "mask set");
      repeat (20) @(posedge clk);
      check("irq raised", {31'h0, irq}, 32'h0000_0001);
      rd(8'h1C, v);
      check("event flag", {31'h0, v[0]}, 32'h0000_0001);
      wr(8'h14, 32'h0000_0001);
      rdChk(8'h18, 32'h0000_0000, "mask clear");
      check("irq masked", {31'h0, irq}, 32'h0000_0000);
      // gated clock: state frozen, duty unreadable, others readable
      @(posedge clk);
      pclkEn <= 1'b0;
      rd(8'h2C, v);
      repeat (10) @(posedge clk);
      rdChk(8'h2C, v, "frozen counter");
      rdChk(8'h24, 32'h0000_0000, "gated duty");
      rdChk(8'h0C, 32'h0000_000F, "gated enabled");
      @(posedge clk);
      pclkEn <= 1'b1;
      // stop one channel only, then polarity is accepted
      wr(8'h08, 32'h0000_0001);
      rdChk(8'h0C, 32'h0000_000E, "one disabled");
      rdChk(8'h2C, 32'h0000_0000, "counter idle");
      check("idle level", {31'h0, waveOut[0]}, {31'h0, cmr[0][9]});
      wr(8'h20, cmr[0] ^ 32'h0000_0300);
      rdChk(8'h20, cmr[0] ^ 32'h0000_0300, "cmr free");
      check("new idle level", {31'h0, waveOut[0]}, {31'h0, ~cmr[0][9]});
      stop_test();
   end
endmodule
